//--- dch_host_bus.sv
// host bus interface: register slave, dma bus master with retry, interrupt and vector
`timescale 1ns/1ps

// Contract
// - Register access while chip selected; dma state only while owning the bus.
// - Two register select lines choose the internal register accessed.
// - Address strobe is an input outside dma, sampled during arbitration.
// - In dma the address strobe is driven, asserted after the address is valid.
// - Byte strobes are lane-select inputs outside dma, outputs in dma.
// - Read level high drives register onto bus; low captures bus data.
// - Read/write driven in dma to show cycle type, floated otherwise.
// - Chip select low enters register access; high deselects.
// - Chip select is ignored while in dma state.
// - Transfer ack asserted after write latch, or when read/vector data valid.
// - Transfer ack driven high when chip select or interrupt ack negates.
// - Retry halts dma, floats lines except grant ack, then reruns the cycle.
// - Second retry records error, aborts dma, releases bus, interrupts host.
// - Retry input is ignored outside dma state.
// - Master reset clears registers and loads the vector register default.
// - Master reset floats every two-way line and enters idle.
// - Open-drain interrupt request asserts at the end of each command.
// - Interrupt acknowledge places the vector on the bus and asserts transfer ack.
// - Bus request asserts for dma; negates once granted and grant ack asserted.
// - After grant, wait for transfer ack, strobe, grant ack idle, then take bus.
// - Grant ack held throughout dma up to the release state, floated in release and all other states.
module dch_host_bus
  import dch_pkg::*;
#(
  parameter int CNT_BITS = CNT_W
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  chip_select_n,
  input  wire logic                  int_ack_n,
  input  wire logic                  bus_retry_n,
  input  wire logic                  bus_grant_n,
  input  wire logic [dch_pkg::DATA_W-1:0] data_i,
  output logic      [dch_pkg::DATA_W-1:0] data_o,
  output logic                       data_oe,
  input  wire logic [dch_pkg::SEL_W-1:0]  register_select_lines_i,
  output logic      [dch_pkg::SEL_W-1:0]  register_select_lines_o,
  output logic                       register_select_lines_oe,
  input  wire logic                  addr_strobe_n_i,
  output logic                       addr_strobe_n_o,
  output logic                       addr_strobe_n_oe,
  input  wire logic                  upper_byte_strobe_n_i,
  output logic                       upper_byte_strobe_n_o,
  output logic                       upper_byte_strobe_n_oe,
  input  wire logic                  lower_byte_strobe_n_i,
  output logic                       lower_byte_strobe_n_o,
  output logic                       lower_byte_strobe_n_oe,
  input  wire logic                  read_not_write_i,
  output logic                       read_not_write_o,
  output logic                       read_not_write_oe,
  input  wire logic                  transfer_ack_n_i,
  output logic                       transfer_ack_n_o,
  output logic                       transfer_ack_n_oe,
  input  wire logic                  grant_ack_n_i,
  output logic                       grant_ack_n_o,
  output logic                       grant_ack_n_oe,
  output logic                       bus_request_n_o,
  output logic                       bus_request_n_oe,
  output logic                       int_request_n_o,
  output logic                       int_request_n_oe,
  input  wire logic                  cmd_done,
  input  wire logic                  dma_go,
  input  wire logic                  dma_dir_read,
  input  wire logic [CNT_BITS-1:0]   dma_words,
  input  wire logic [dch_pkg::SEL_W-1:0]  dma_sel,
  input  wire logic [1:0]            dma_lanes,
  input  wire logic [dch_pkg::DATA_W-1:0] dma_wdata,
  output logic      [dch_pkg::DATA_W-1:0] dma_rdata,
  output logic                       dma_word,
  output logic                       dma_done,
  output logic                       dma_busy,
  output logic      [dch_pkg::REG_W-1:0]  cmd_reg,
  output logic      [dch_pkg::REG_W-1:0]  param_reg,
  output logic                       cmd_wr
);
  import dch_pkg::*;

  typedef struct packed {
    dch_state_t          st;
    logic                rd_cyc;
    logic [DATA_W-1:0]   dout;
    logic [REG_W-1:0]    cmd;
    logic [REG_W-1:0]    param;
    logic [REG_W-1:0]    vector;
    logic [ERR_W-1:0]    err;
    logic                irq;
    logic                pend;
    logic                dir_rd;
    logic [CNT_BITS-1:0] cnt;
    logic [SEL_W-1:0]    sel;
    logic [1:0]          lanes;
    logic                retried;
    logic [DATA_W-1:0]   rdata;
    logic                word_p;
    logic                done_p;
    logic                cmd_p;
  } dch_regs_t;

  dch_regs_t r_q;
  dch_regs_t r_d;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int SW = 10;
  logic [SW-1:0]     pins_raw;
  logic [SW-1:0]     pins_s;
  logic [DATA_W-1:0] data_s;
  logic [SEL_W-1:0]  sel_s;

  assign pins_raw = {chip_select_n, int_ack_n, bus_retry_n, bus_grant_n, addr_strobe_n_i,
                     upper_byte_strobe_n_i, lower_byte_strobe_n_i, read_not_write_i,
                     transfer_ack_n_i, grant_ack_n_i};

  dch_sync #(.W(SW), .RST_VAL({SW{1'b1}})) u_sync_pins (
    .mclk (mclk),
    .rst  (rst),
    .d    (pins_raw),
    .q    (pins_s)
  );

  dch_sync #(.W(DATA_W + SEL_W), .RST_VAL('0)) u_sync_data (
    .mclk (mclk),
    .rst  (rst),
    .d    ({data_i, register_select_lines_i}),
    .q    ({data_s, sel_s})
  );

  logic cs_n_s, iack_n_s, retry_n_s, bg_n_s, as_n_s, uds_n_s, lds_n_s, rnw_s, dtack_n_s, bgack_n_s;
  assign {cs_n_s, iack_n_s, retry_n_s, bg_n_s, as_n_s, uds_n_s, lds_n_s, rnw_s, dtack_n_s,
          bgack_n_s} = pins_s;

  // ---------------------------------------------------------------
  // register helpers
  // ---------------------------------------------------------------
  function automatic logic [REG_W-1:0] status_byte(input dch_regs_t r);
    logic [REG_W-1:0] s;
    s = '0;
    s[STS_IRQ_BIT] = r.irq;
    s[STS_ERR_LSB +: ERR_W] = r.err;
    s[STS_BUSY_BIT] = r.pend;
    return s;
  endfunction

  function automatic logic dma_state(input dch_state_t s);
    return (s == ST_DMA_ADDR) || (s == ST_DMA_STRB) || (s == ST_DMA_WAIT) ||
           (s == ST_DMA_END) || (s == ST_DMA_HALT) || (s == ST_DMA_REL);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic irq_set;
  logic irq_clr;

  always_comb begin
    logic [REG_W-1:0] wv;
    wv = '0;
    r_d = r_q;
    r_d.word_p = 1'b0;
    r_d.done_p = 1'b0;
    r_d.cmd_p  = 1'b0;
    irq_set = cmd_done;
    irq_clr = 1'b0;
    if (dma_go && !r_q.pend) begin
      r_d.pend   = 1'b1;
      r_d.dir_rd = dma_dir_read;
      r_d.cnt    = dma_words;
      r_d.sel    = dma_sel;
      r_d.lanes  = dma_lanes;
      r_d.err    = ERR_NONE;
    end
    case (r_q.st)
      ST_IDLE: begin
        if (!iack_n_s && !as_n_s) begin
          r_d.dout   = {r_q.vector, r_q.vector};
          r_d.rd_cyc = 1'b1;
          irq_clr    = 1'b1;
          r_d.st     = ST_REG;
        end else if (!cs_n_s && (!uds_n_s || !lds_n_s)) begin
          r_d.rd_cyc = rnw_s;
          r_d.st     = ST_REG;
          if (rnw_s) begin
            case (sel_s)
              REG_CMD:    r_d.dout = {r_q.cmd, r_q.cmd};
              REG_STATUS: r_d.dout = {status_byte(r_q), status_byte(r_q)};
              REG_PARAM:  r_d.dout = {r_q.param, r_q.param};
              default:    r_d.dout = {r_q.vector, r_q.vector};
            endcase
            irq_clr = (sel_s == REG_STATUS);
          end else begin
            wv = lds_n_s ? data_s[LANE_HI_LSB +: REG_W] : data_s[LANE_LO_LSB +: REG_W];
            case (sel_s)
              REG_CMD: begin
                r_d.cmd   = wv;
                r_d.cmd_p = 1'b1;
              end
              REG_PARAM:  r_d.param  = wv;
              REG_VECTOR: r_d.vector = wv;
              default:    r_d.cmd    = r_q.cmd;
            endcase
          end
        end else if (r_q.pend) begin
          r_d.st = ST_ARB_REQ;
        end
      end
      ST_REG: r_d.st = ST_REG_ACK;
      ST_REG_ACK: begin
        if (cs_n_s && iack_n_s) begin
          r_d.st = ST_REG_REL;
        end
      end
      ST_REG_REL: begin
        r_d.rd_cyc = 1'b0;
        r_d.st     = ST_IDLE;
      end
      ST_ARB_REQ: begin
        if (!bg_n_s) begin
          r_d.st = ST_ARB_WAIT;
        end
      end
      ST_ARB_WAIT: begin
        if (dtack_n_s && as_n_s && bgack_n_s) begin
          r_d.st = ST_DMA_ADDR;
        end
      end
      ST_DMA_ADDR: begin
        r_d.dout = dma_wdata;
        r_d.st   = ST_DMA_STRB;
      end
      ST_DMA_STRB: r_d.st = ST_DMA_WAIT;
      ST_DMA_WAIT: begin
        if (!retry_n_s) begin
          if (r_q.retried) begin
            r_d.err  = ERR_RETRY;
            irq_set  = 1'b1;
            r_d.pend = 1'b0;
            r_d.st   = ST_DMA_REL;
          end else begin
            r_d.retried = 1'b1;
            r_d.st      = ST_DMA_HALT;
          end
        end else if (!dtack_n_s) begin
          r_d.rdata   = data_s;
          r_d.word_p  = 1'b1;
          r_d.retried = 1'b0;
          r_d.st      = ST_DMA_END;
        end
      end
      ST_DMA_HALT: begin
        if (retry_n_s) begin
          r_d.st = ST_DMA_ADDR;
        end
      end
      ST_DMA_END: begin
        if (dtack_n_s) begin
          if (r_q.cnt == '0) begin
            r_d.pend   = 1'b0;
            r_d.done_p = 1'b1;
            r_d.st     = ST_DMA_REL;
          end else begin
            // count words left only after a word ends, so zero means one word
            r_d.cnt = r_q.cnt - CNT_BITS'(1);
            r_d.st  = ST_DMA_ADDR;
          end
        end
      end
      ST_DMA_REL: r_d.st = ST_IDLE;
      default: r_d.st = ST_IDLE;
    endcase
    r_d.irq = irq_set | (r_q.irq & ~irq_clr);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      r_q        <= '0;
      r_q.st     <= ST_IDLE;
      r_q.cmd    <= REG_RST;
      r_q.param  <= REG_RST;
      r_q.vector <= VECTOR_RST;
      r_q.err    <= ERR_NONE;
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  logic in_dma;
  logic strobe_on;
  logic master_drv;

  assign in_dma     = dma_state(r_q.st) && !rst;
  assign strobe_on  = (r_q.st == ST_DMA_STRB) || (r_q.st == ST_DMA_WAIT);
  assign master_drv = in_dma && (r_q.st != ST_DMA_HALT) && (r_q.st != ST_DMA_REL);

  assign data_o  = r_q.dout;
  assign data_oe = !rst && ((r_q.rd_cyc && ((r_q.st == ST_REG) || (r_q.st == ST_REG_ACK))) ||
                            (master_drv && !r_q.dir_rd));

  assign register_select_lines_o  = r_q.sel;
  assign register_select_lines_oe = master_drv;

  assign addr_strobe_n_o  = !strobe_on;
  assign addr_strobe_n_oe = master_drv;

  assign upper_byte_strobe_n_o  = !(strobe_on && r_q.lanes[1]);
  assign upper_byte_strobe_n_oe = master_drv;
  assign lower_byte_strobe_n_o  = !(strobe_on && r_q.lanes[0]);
  assign lower_byte_strobe_n_oe = master_drv;

  assign read_not_write_o  = r_q.dir_rd;
  assign read_not_write_oe = master_drv;

  assign transfer_ack_n_o  = (r_q.st != ST_REG_ACK);
  assign transfer_ack_n_oe = !rst && ((r_q.st == ST_REG_ACK) || (r_q.st == ST_REG_REL));

  assign grant_ack_n_o  = 1'b0;
  assign grant_ack_n_oe = in_dma && (r_q.st != ST_DMA_REL);

  assign bus_request_n_o  = 1'b0;
  assign bus_request_n_oe = !rst && ((r_q.st == ST_ARB_REQ) || (r_q.st == ST_ARB_WAIT));

  assign int_request_n_o  = 1'b0;
  assign int_request_n_oe = r_q.irq;

  assign dma_rdata = r_q.rdata;
  assign dma_word  = r_q.word_p;
  assign dma_done  = r_q.done_p;
  assign dma_busy  = r_q.pend;
  assign cmd_reg   = r_q.cmd;
  assign param_reg = r_q.param;
  assign cmd_wr    = r_q.cmd_p;
endmodule

//--- dch_pkg.sv
// package of shared constants and the pin synchroniser of the host bus interface
`timescale 1ns/1ps
package dch_pkg;
  localparam int DATA_W      = 16;
  localparam int REG_W       = 8;
  localparam int SEL_W       = 2;
  localparam int CNT_W       = 16;
  localparam int ERR_W       = 3;
  localparam int SYNC_STAGES = 2;

  // register indices on the register select lines
  localparam logic [SEL_W-1:0] REG_CMD    = 2'h0;
  localparam logic [SEL_W-1:0] REG_STATUS = 2'h1;
  localparam logic [SEL_W-1:0] REG_PARAM  = 2'h2;
  localparam logic [SEL_W-1:0] REG_VECTOR = 2'h3;

  // reset values
  localparam logic [REG_W-1:0] VECTOR_RST = 8'h0f;
  localparam logic [REG_W-1:0] REG_RST    = 8'h00;

  // main status byte layout
  localparam int STS_IRQ_BIT  = 7;
  localparam int STS_ERR_LSB  = 4;
  localparam int STS_BUSY_BIT = 0;
  localparam logic [ERR_W-1:0] ERR_NONE  = 3'h0;
  localparam logic [ERR_W-1:0] ERR_RETRY = 3'h5;

  // byte lanes within the data bus
  localparam int LANE_LO_LSB = 0;
  localparam int LANE_HI_LSB = 8;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_REG,
    ST_REG_ACK,
    ST_REG_REL,
    ST_ARB_REQ,
    ST_ARB_WAIT,
    ST_DMA_ADDR,
    ST_DMA_STRB,
    ST_DMA_WAIT,
    ST_DMA_END,
    ST_DMA_HALT,
    ST_DMA_REL
  } dch_state_t;
endpackage

// ---------------------------------------------------------------
// two-flop synchroniser for pin inputs
// ---------------------------------------------------------------
module dch_sync #(
  parameter int                   W       = 1,
  parameter logic [W-1:0]         RST_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

//--- dch_host_bus_props.sv
// checker of the host bus interface pin behaviour
`timescale 1ns/1ps
module dch_host_bus_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic bus_grant_n,
  input wire logic addr_strobe_n_i,
  input wire logic transfer_ack_n_i,
  input wire logic grant_ack_n_i,
  input wire logic cmd_done,
  input wire logic dma_done,
  input wire logic data_oe,
  input wire logic read_not_write_oe,
  input wire logic addr_strobe_n_oe,
  input wire logic lower_byte_strobe_n_oe,
  input wire logic transfer_ack_n_o,
  input wire logic transfer_ack_n_oe,
  input wire logic grant_ack_n_o,
  input wire logic grant_ack_n_oe,
  input wire logic bus_request_n_oe,
  input wire logic int_request_n_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_gack_level: assert property (grant_ack_n_oe |-> !grant_ack_n_o)
    else $error("grant ack driven high");
  a_rw_dma_only: assert property (read_not_write_oe |-> grant_ack_n_oe)
    else $error("read level driven outside dma");
  a_as_dma_only: assert property (addr_strobe_n_oe |-> grant_ack_n_oe)
    else $error("address strobe driven outside dma");
  a_ds_dma_only: assert property (lower_byte_strobe_n_oe |-> grant_ack_n_oe)
    else $error("byte strobe driven outside dma");
  a_req_dropped: assert property (grant_ack_n_oe |-> !bus_request_n_oe)
    else $error("request held while owning bus");
  a_take_quiet: assert property ($rose(grant_ack_n_oe) |-> !$past(bus_grant_n, 3) &&
    $past(addr_strobe_n_i, 3) && $past(transfer_ack_n_i, 3) && $past(grant_ack_n_i, 3))
    else $error("bus taken while not quiet");
  a_ack_high_end: assert property ($fell(transfer_ack_n_oe) |-> $past(transfer_ack_n_o))
    else $error("ack floated without driving high");
  a_no_reg_dma: assert property (transfer_ack_n_oe |-> !grant_ack_n_oe)
    else $error("register answer during dma");
  a_irq_on_cmd: assert property (cmd_done |-> ##[1:3] int_request_n_oe)
    else $error("no interrupt after command end");
  a_done_free: assert property (dma_done |-> !grant_ack_n_oe && !addr_strobe_n_oe)
    else $error("bus kept after dma end");
  a_rst_float: assert property (disable iff (1'h0) rst |=> !data_oe && !grant_ack_n_oe &&
    !transfer_ack_n_oe && !bus_request_n_oe)
    else $error("line driven after reset");
  c_dma_done: cover property (dma_done);
  c_reg_end: cover property ($fell(transfer_ack_n_oe));
  c_irq: cover property ($rose(int_request_n_oe));
endmodule

bind dch_host_bus dch_host_bus_chk u_chk (.*);

//--- dch_mem_model.sv
// partner model: bus arbiter and memory answering dma cycles
`timescale 1ns/1ps
module dch_mem_model #(
  parameter logic [15:0] RD_VAL  = 16'h5a3c,
  parameter int          ACK_DLY = 2
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        brq_n,
  input  wire logic        as_n,
  input  wire logic        ds_n,
  input  wire logic        rnw,
  input  wire logic        gack_n,
  input  wire logic [15:0] din,
  input  wire logic [1:0]  retries,
  output logic             grant_n,
  output logic             ack_n,
  output logic             retry_n,
  output logic             dout_oe,
  output logic [15:0]      dout,
  output logic [15:0]      last_wr,
  output logic [7:0]       wr_cnt
);
  logic [1:0] left;
  int         wait_n;
  logic       done;
  // released data shows the inverse so a stale read cannot match
  assign dout = dout_oe ? RD_VAL : ~RD_VAL;
  always_ff @(posedge mclk) begin
    if (rst) begin
      grant_n <= 1'h1;
      ack_n <= 1'h1;
      retry_n <= 1'h1;
      dout_oe <= 1'h0;
      left <= 2'h0;
      wait_n <= 0;
      done <= 1'h0;
      wr_cnt <= 8'h0;
      last_wr <= 16'h0;
    end else begin
      grant_n <= brq_n;
      retry_n <= 1'h1;
      if (gack_n) left <= retries;
      if (as_n) begin
        ack_n <= 1'h1;
        dout_oe <= 1'h0;
        done <= 1'h0;
        wait_n <= 0;
      end else if (!gack_n && !ds_n && !done) begin
        wait_n <= wait_n + 1;
        if (wait_n == ACK_DLY) begin
          done <= 1'h1;
          if (left != 2'h0) begin
            retry_n <= 1'h0;
            left <= left - 2'h1;
          end else begin
            ack_n <= 1'h0;
            dout_oe <= rnw;
            if (!rnw) last_wr <= din;
            if (!rnw) wr_cnt <= wr_cnt + 8'h1;
          end
        end
      end
    end
  end
endmodule

//--- tb_dch_host_bus.sv
// self-checking testbench of the host bus interface
`timescale 1ns/1ps
module tb_dch_host_bus;
  import dch_pkg::*;
  localparam logic [15:0] RDV = 16'h5a3c;
  logic        mclk = 1'h0, rst = 1'h1, cs_n = 1'h1, ia_n = 1'h1, cdone = 1'h0, go = 1'h0;
  logic        dir = 1'h0, h_rw = 1'h1, h_us = 1'h1, h_ls = 1'h1, h_as = 1'h1;
  logic [1:0]  h_sel = 2'h0, m_rt = 2'h0, rs_o;
  logic [15:0] h_d = 16'h0, nw = 16'h0, wdat = 16'h0, do_, rdat, m_d, m_wr, q;
  logic [7:0]  creg, preg, m_cnt;
  logic        do_oe, rs_oe, as_o, as_oe, us_o, us_oe, ls_o, ls_oe, rw_o, rw_oe, ak_o, ak_oe;
  logic        ga_o, ga_oe, br_o, br_oe, ir_o, ir_oe, wd_p, dn_p, busy, cwr, m_gn, m_ak, m_rn;
  logic        m_oe;
  int          fail_count = 0, tests_run = 0, cw = 0;
  wire         as_w = as_oe ? as_o : h_as;
  wire         us_w = us_oe ? us_o : h_us;
  wire         ls_w = ls_oe ? ls_o : h_ls;
  wire         rw_w = rw_oe ? rw_o : h_rw;
  wire         ak_w = ak_oe ? ak_o : m_ak;
  wire         ga_w = ga_oe ? ga_o : 1'h1;
  wire [15:0]  d_w = do_oe ? do_ : (m_oe || (cs_n & ia_n) ? m_d : h_d);

  always #50 mclk = ~mclk;
  always @(posedge mclk) cw += (cwr === 1'h1);

  dch_host_bus DUT (
    .mclk(mclk), .rst(rst), .chip_select_n(cs_n), .int_ack_n(ia_n), .bus_retry_n(m_rn),
    .bus_grant_n(m_gn), .data_i(d_w), .data_o(do_), .data_oe(do_oe),
    .register_select_lines_i(rs_oe ? rs_o : h_sel), .register_select_lines_o(rs_o),
    .register_select_lines_oe(rs_oe), .addr_strobe_n_i(as_w), .addr_strobe_n_o(as_o),
    .addr_strobe_n_oe(as_oe), .upper_byte_strobe_n_i(us_w), .upper_byte_strobe_n_o(us_o),
    .upper_byte_strobe_n_oe(us_oe), .lower_byte_strobe_n_i(ls_w),
    .lower_byte_strobe_n_o(ls_o), .lower_byte_strobe_n_oe(ls_oe), .read_not_write_i(rw_w),
    .read_not_write_o(rw_o), .read_not_write_oe(rw_oe), .transfer_ack_n_i(ak_w),
    .transfer_ack_n_o(ak_o), .transfer_ack_n_oe(ak_oe), .grant_ack_n_i(ga_w),
    .grant_ack_n_o(ga_o), .grant_ack_n_oe(ga_oe), .bus_request_n_o(br_o),
    .bus_request_n_oe(br_oe), .int_request_n_o(ir_o), .int_request_n_oe(ir_oe),
    .cmd_done(cdone), .dma_go(go), .dma_dir_read(dir), .dma_words(nw), .dma_sel(2'h2),
    .dma_lanes(2'h3), .dma_wdata(wdat), .dma_rdata(rdat), .dma_word(wd_p), .dma_done(dn_p),
    .dma_busy(busy), .cmd_reg(creg), .param_reg(preg), .cmd_wr(cwr)
  );

  dch_mem_model #(.RD_VAL(RDV)) MEM (
    .mclk(mclk), .rst(rst), .brq_n(br_oe ? br_o : 1'h1), .as_n(as_w), .ds_n(us_w & ls_w),
    .rnw(rw_w), .gack_n(ga_w), .din(d_w), .retries(m_rt), .grant_n(m_gn), .ack_n(m_ak),
    .retry_n(m_rn), .dout_oe(m_oe), .dout(m_d), .last_wr(m_wr), .wr_cnt(m_cnt)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // host register or vector cycle; read data lands in q
  task automatic hcyc(input logic ia, input logic rd, input logic [1:0] sel,
                      input logic [1:0] ln, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    h_rw <= rd;
    h_sel <= sel;
    h_d <= wd;
    h_ls <= !ln[0];
    h_us <= !ln[1];
    h_as <= 1'h0;
    cs_n <= ia;
    ia_n <= !ia;
    do @(posedge mclk); while (!(ak_oe === 1'h1 && ak_o === 1'h0) && ++n < 40);
    q = d_w;
    chk(16'(n < 40), 16'h1);
    cs_n <= 1'h1;
    ia_n <= 1'h1;
    h_ls <= 1'h1;
    h_us <= 1'h1;
    h_as <= 1'h1;
    n = 0;
    do @(posedge mclk); while (ak_oe !== 1'h0 && ++n < 40);
  endtask

  task automatic pulse_done;
    @(posedge mclk);
    cdone <= 1'h1;
    @(posedge mclk);
    cdone <= 1'h0;
    repeat (4) @(posedge mclk);
    chk(16'(ir_oe), 16'h1);
  endtask

  task automatic t_reset;
    hcyc(1'h1, 1'h1, REG_VECTOR, 2'h3, 16'h0);
    chk(q, {VECTOR_RST, VECTOR_RST});
    hcyc(1'h0, 1'h1, REG_STATUS, 2'h3, 16'h0);
    chk(q, 16'h0);
  endtask

  task automatic t_regs;
    hcyc(1'h0, 1'h0, REG_PARAM, 2'h1, 16'h12a5);
    chk({8'h0, preg}, 16'h00a5);
    hcyc(1'h0, 1'h0, REG_PARAM, 2'h2, 16'h3c77);
    chk({8'h0, preg}, 16'h003c);
    hcyc(1'h0, 1'h1, REG_PARAM, 2'h3, 16'h0);
    chk(q, 16'h3c3c);
    hcyc(1'h0, 1'h0, REG_STATUS, 2'h1, 16'h00ff);
    hcyc(1'h0, 1'h1, REG_STATUS, 2'h3, 16'h0);
    chk(q, 16'h0);
    hcyc(1'h0, 1'h0, REG_VECTOR, 2'h1, 16'h0042);
    hcyc(1'h0, 1'h0, REG_CMD, 2'h1, 16'h0081);
    chk({8'h0, creg}, 16'h0081);
    chk(16'(cw), 16'h1);
  endtask

  task automatic t_irq;
    pulse_done();
    hcyc(1'h0, 1'h1, REG_STATUS, 2'h3, 16'h0);
    chk(q, 16'h8080);
    chk(16'(ir_oe), 16'h0);
    pulse_done();
    hcyc(1'h1, 1'h1, REG_VECTOR, 2'h3, 16'h0);
    chk(q, 16'h4242);
    chk(16'(ir_oe), 16'h0);
  endtask

  // dma run; host selects the chip meanwhile when more than one word moves
  task automatic t_dma(input logic rd, input logic [1:0] rt, input logic [15:0] w,
                       input logic dn, input int ew);
    int         n, k, d;
    logic [7:0] c0;
    n = 0;
    k = 0;
    d = 0;
    c0 = m_cnt;
    @(posedge mclk);
    dir <= rd;
    nw <= w;
    wdat <= 16'hc3a0 ^ w;
    m_rt <= rt;
    go <= 1'h1;
    @(posedge mclk);
    go <= 1'h0;
    while (n < 400 && !(n > 8 && busy === 1'h0)) begin
      @(posedge mclk);
      n++;
      if (n == 6 && w != 16'h0) begin
        cs_n <= 1'h0;
        h_ls <= 1'h0;
      end
      if (wd_p === 1'h1) begin
        k++;
        chk(16'({rs_oe, rs_o}), 16'h0006);
        cs_n <= 1'h1;
        h_ls <= 1'h1;
      end
      d += (dn_p === 1'h1);
    end
    repeat (2) begin
      @(posedge mclk);
      d += (dn_p === 1'h1);
    end
    chk(16'(n < 400), 16'h1);
    chk(16'(k), 16'(ew));
    chk(16'(d), 16'(dn));
    if (rd) chk(rdat, RDV);
    else chk(16'(m_cnt - c0), 16'(ew));
    if (!rd && ew > 0) chk(m_wr, wdat);
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    repeat (3) @(posedge mclk);
    t_reset();
    t_regs();
    t_irq();
    t_dma(1'h0, 2'h0, 16'h1, 1'h1, 2);
    t_dma(1'h1, 2'h0, 16'h0, 1'h1, 1);
    t_dma(1'h0, 2'h1, 16'h0, 1'h1, 1);
    t_dma(1'h0, 2'h2, 16'h0, 1'h0, 0);
    chk(16'(ir_oe), 16'h1);
    hcyc(1'h0, 1'h1, REG_STATUS, 2'h3, 16'h0);
    chk(q, 16'hd0d0);
    @(posedge mclk);
    rst <= 1'h1;
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    repeat (3) @(posedge mclk);
    t_reset();
    results();
  end

  initial begin
    #3000000;
    fail_count++;
    results();
  end
endmodule
